/* tb/iprio_regs_tb.sv */
// Self-checking bench for the priority control registers
`timescale 1ns/100ps
module iprio_regs_tb;
    import iprio_pkg::*;
    logic                CLK, RST_N, WR, RD, rd_seen;
    logic [AW-1:0]       ADDR;
    logic [DW-1:0]       WDATA, RDATA;
    logic [NSRC-1:0]     FLAG, ENABLE, REQUEST;
    logic [NSRC*PW-1:0]  PRIORITY;
    logic [DW-1:0]       m [NREG];
    logic [DW-1:0]       exp_q [$];
    logic [DW-1:0]       mask [NREG] = '{16'h7707, 16'h7770, 16'h7777, 16'h0077};
    int                  num_errors = 0;
    int                  check_count = 0;

    iprio_regs DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .FLAG(FLAG), .ENABLE(ENABLE), .PRIORITY(PRIORITY),
        .REQUEST(REQUEST));

    task automatic chk(input logic [NSRC*PW-1:0] got, input logic [NSRC*PW-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected field vector from the register model, source 0 lowest
    function automatic logic [NSRC*PW-1:0] exp_prio();
        exp_prio = {m[3][2:0], m[3][6:4], m[2][2:0], m[2][6:4], m[2][10:8], m[2][14:12],
            m[1][6:4], m[1][10:8], m[1][14:12], m[0][2:0], m[0][10:8], m[0][14:12]};
    endfunction
    function automatic logic [NSRC-1:0] exp_req(input logic [NSRC*PW-1:0] p);
        for (int s = 0; s < NSRC; s++)
            exp_req[s] = FLAG[s] & ENABLE[s] & (p[s*PW +: PW] != '0);
    endfunction
    task automatic wr(input int a, input logic [DW-1:0] d);
        @(posedge CLK);
        ADDR <= AW'(a);
        WDATA <= d;
        WR <= 1'b1;
        RD <= 1'b0;
        m[a] = d & mask[a];
    endtask
    task automatic rd(input int a);
        @(posedge CLK);
        ADDR <= AW'(a);
        RD <= 1'b1;
        WR <= 1'b0;
        exp_q.push_back(m[a]);
    endtask
    task automatic idle();
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // Read data stand only in the cycle after the read strobe
    always @(negedge CLK)
    begin
        if (rd_seen === 1'b1)
            chk(RDATA, exp_q.pop_front());
        rd_seen <= RD;
    end
    initial
    begin
        #80000;
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        {RST_N, WR, RD, rd_seen, ADDR, WDATA, FLAG, ENABLE} = '0;
        void'($urandom(32'h8239));
        for (int i = 0; i < NREG; i++) m[i] = mask[i] & 16'h4444;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < NREG; i++) rd(i);
        idle();
        chk(PRIORITY, exp_prio());
        $display("reset values done");
        for (int i = 0; i < NREG; i++)
        begin
            wr(i, 16'hffff);
            rd(i);
            wr(i, DW'($urandom));
            rd(i);
        end
        idle();
        chk(PRIORITY, exp_prio());
        $display("field layout done");
        wr(3, 16'h0010);
        FLAG <= '1;
        ENABLE <= '1;
        idle();
        chk(DW'(REQUEST[11:10]), 16'h0001);
        chk(DW'(PRIORITY[35:30]), 16'h0001);
        wr(3, 16'h0070);
        FLAG <= NSRC'($urandom);
        ENABLE <= NSRC'($urandom);
        idle();
        chk(DW'(PRIORITY[32:30]), 16'h0007);
        chk(DW'(REQUEST[11:10]), DW'({1'b0, FLAG[10] & ENABLE[10]}));
        chk(REQUEST, exp_req(exp_prio()));
        $display("request gating done");
        // Reset in mid-run returns every written field to the reset code
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < NREG; i++) m[i] = mask[i] & 16'h4444;
        for (int i = 0; i < NREG; i++) rd(i);
        idle();
        chk(PRIORITY, exp_prio());
        chk(REQUEST, exp_req(exp_prio()));
        $display("mid-run reset done");
        repeat (2) @(posedge CLK);
        report_and_stop();
    end
endmodule

/* verilog/iprio_field.sv */
// One 3-bit priority field with its request gating
`timescale 1ns/100ps
module iprio_field
(
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    input  wire logic                     wr,
    input  wire logic [iprio_pkg::PW-1:0] wdata,
    input  wire logic                     flag,
    input  wire logic                     enable,
    output logic      [iprio_pkg::PW-1:0] prio,
    output logic                          req
);
    import iprio_pkg::*;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prio <= PRIO_RESET;
        end
        else if (wr)
        begin
            prio <= wdata;
        end
    end

    assign req = flag && enable && (prio != PRIO_DISABLED);

    a_disabled_no_req: assert property (@(posedge CLK) disable iff (!RST_N)
        (prio == PRIO_DISABLED) |-> !req)
        else $error("Disabled source raised request");
    a_write_loads: assert property (@(posedge CLK) disable iff (!RST_N)
        wr |=> prio == $past(wdata))
        else $error("Priority write not stored");
endmodule

/* verilog/iprio_pkg.sv */
// Constants for the priority control registers of capture, timer, serial and SPI sources
package iprio_pkg;
    localparam int DW = 16;
    localparam int AW = 2;
    localparam int PW = 3;
    localparam int NSRC = 12;
    localparam int NREG = 4;

    localparam logic [AW-1:0] ADDR_CAPTURE = 2'h0;
    localparam logic [AW-1:0] ADDR_TIMER   = 2'h1;
    localparam logic [AW-1:0] ADDR_SERIAL  = 2'h2;
    localparam logic [AW-1:0] ADDR_SPI     = 2'h3;

    localparam logic [PW-1:0] PRIO_RESET    = 3'h4;
    localparam logic [PW-1:0] PRIO_DISABLED = 3'h0;

    localparam int LSB_HI  = 12;
    localparam int LSB_MID = 8;
    localparam int LSB_LOW = 4;
    localparam int LSB_BOT = 0;

    // Source index order on the flat vectors
    localparam int SRC_IC8  = 0;
    localparam int SRC_IC7  = 1;
    localparam int SRC_EX1  = 2;
    localparam int SRC_T4   = 3;
    localparam int SRC_OC4  = 4;
    localparam int SRC_OC3  = 5;
    localparam int SRC_UTX  = 6;
    localparam int SRC_URX  = 7;
    localparam int SRC_EX2  = 8;
    localparam int SRC_T5   = 9;
    localparam int SRC_SPE  = 10;
    localparam int SRC_SPF  = 11;
endpackage

/* verilog/iprio_regs.sv */
// Priority control registers for twelve sources with request gating
`timescale 1ns/100ps
module iprio_regs
(
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    input  wire logic [iprio_pkg::AW-1:0]      ADDR,
    input  wire logic [iprio_pkg::DW-1:0]      WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [iprio_pkg::DW-1:0]      RDATA,
    input  wire logic [iprio_pkg::NSRC-1:0]    FLAG,
    input  wire logic [iprio_pkg::NSRC-1:0]    ENABLE,
    output logic [iprio_pkg::NSRC*iprio_pkg::PW-1:0] PRIORITY,
    output logic      [iprio_pkg::NSRC-1:0]    REQUEST
);
    import iprio_pkg::*;

    logic [PW-1:0]   prio  [NSRC];
    logic [NSRC-1:0] wr_f;
    int              lsb   [NSRC];
    logic [AW-1:0]   adr   [NSRC];
    logic [NSRC-1:0] touched;
    logic [DW-1:0]   img   [NREG];
    logic [DW-1:0]   sel_img;

    // Field placement table: register and low bit of each source
    assign lsb[SRC_IC8] = LSB_HI;
    assign adr[SRC_IC8] = ADDR_CAPTURE;
    assign lsb[SRC_IC7] = LSB_MID;
    assign adr[SRC_IC7] = ADDR_CAPTURE;
    assign lsb[SRC_EX1] = LSB_BOT;
    assign adr[SRC_EX1] = ADDR_CAPTURE;
    assign lsb[SRC_T4]  = LSB_HI;
    assign adr[SRC_T4]  = ADDR_TIMER;
    assign lsb[SRC_OC4] = LSB_MID;
    assign adr[SRC_OC4] = ADDR_TIMER;
    assign lsb[SRC_OC3] = LSB_LOW;
    assign adr[SRC_OC3] = ADDR_TIMER;
    assign lsb[SRC_UTX] = LSB_HI;
    assign adr[SRC_UTX] = ADDR_SERIAL;
    assign lsb[SRC_URX] = LSB_MID;
    assign adr[SRC_URX] = ADDR_SERIAL;
    assign lsb[SRC_EX2] = LSB_LOW;
    assign adr[SRC_EX2] = ADDR_SERIAL;
    assign lsb[SRC_T5]  = LSB_BOT;
    assign adr[SRC_T5]  = ADDR_SERIAL;
    assign lsb[SRC_SPE] = LSB_LOW;
    assign adr[SRC_SPE] = ADDR_SPI;
    assign lsb[SRC_SPF] = LSB_BOT;
    assign adr[SRC_SPF] = ADDR_SPI;

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            assign wr_f[g] = WR && (ADDR == adr[g]);
            iprio_field u_field (
                .CLK    (CLK),
                .RST_N  (RST_N),
                .wr     (wr_f[g]),
                .wdata  (WDATA[lsb[g] +: PW]),
                .flag   (FLAG[g]),
                .enable (ENABLE[g]),
                .prio   (prio[g]),
                .req    (REQUEST[g])
            );
            assign PRIORITY[g*PW +: PW] = prio[g];
        end
    endgenerate

    // Read images; bits outside any field stay zero
    always_comb
    begin
        for (int r = 0; r < NREG; r++)
        begin
            img[r] = '0;
        end
        for (int s = 0; s < NSRC; s++)
        begin
            img[adr[s]][lsb[s] +: PW] = prio[s];
        end
    end

    assign sel_img = img[ADDR];

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RDATA <= '0;
        end
        else
        begin
            RDATA <= RD ? sel_img : '0;
        end
    end

    a_spi_upper_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SPI) |=> RDATA[DW-1:LSB_LOW+PW] == '0)
        else $error("SPI reg upper bits set");
    a_capture_bit_pos: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_CAPTURE) |=> prio[SRC_IC8] == $past(WDATA[LSB_HI +: PW]))
        else $error("Capture 8 field misplaced");
    a_ext_two_pos: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SERIAL) |=> prio[SRC_EX2] == $past(WDATA[LSB_LOW +: PW]))
        else $error("Ext irq 2 field misplaced");
    a_spi_fault_pos: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SPI) |=> prio[SRC_SPF] == $past(WDATA[LSB_BOT +: PW]))
        else $error("SPI fault field misplaced");
    a_unused_bits_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        RD |=> (!RDATA[LSB_HI+PW] && !RDATA[LSB_MID+PW] && !RDATA[LSB_BOT+PW]))
        else $error("Unused bit read nonzero");
    a_top_code_reqs: assert property (@(posedge CLK) disable iff (!RST_N)
        ((&prio[SRC_T4]) && FLAG[SRC_T4] && ENABLE[SRC_T4]) |-> REQUEST[SRC_T4])
        else $error("Level seven not requesting");
    a_no_read_idle: assert property (@(posedge CLK) disable iff (!RST_N)
        !RD |=> RDATA == '0)
        else $error("Read data without strobe");

    // Each write lands its field from the documented bit slot
    a_ic7_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_CAPTURE) |=> prio[SRC_IC7] == $past(WDATA[LSB_MID +: PW]))
        else $error("Capture 7 field misplaced");
    a_ex1_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_CAPTURE) |=> prio[SRC_EX1] == $past(WDATA[LSB_BOT +: PW]))
        else $error("Ext irq 1 field misplaced");
    a_t4_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_TIMER) |=> prio[SRC_T4] == $past(WDATA[LSB_HI +: PW]))
        else $error("Timer 4 field misplaced");
    a_oc4_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_TIMER) |=> prio[SRC_OC4] == $past(WDATA[LSB_MID +: PW]))
        else $error("Compare 4 field misplaced");
    a_oc3_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_TIMER) |=> prio[SRC_OC3] == $past(WDATA[LSB_LOW +: PW]))
        else $error("Compare 3 field misplaced");
    a_utx_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SERIAL) |=> prio[SRC_UTX] == $past(WDATA[LSB_HI +: PW]))
        else $error("Serial tx field misplaced");
    a_urx_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SERIAL) |=> prio[SRC_URX] == $past(WDATA[LSB_MID +: PW]))
        else $error("Serial rx field misplaced");
    a_t5_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SERIAL) |=> prio[SRC_T5] == $past(WDATA[LSB_BOT +: PW]))
        else $error("Timer 5 field misplaced");
    a_spe_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == ADDR_SPI) |=> prio[SRC_SPE] == $past(WDATA[LSB_LOW +: PW]))
        else $error("SPI event field misplaced");

    // Each field reads back from the same slot it was written to
    a_ic8_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_CAPTURE) |=> RDATA[LSB_HI +: PW] == $past(prio[SRC_IC8]))
        else $error("Capture 8 read misplaced");
    a_ic7_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_CAPTURE) |=> RDATA[LSB_MID +: PW] == $past(prio[SRC_IC7]))
        else $error("Capture 7 read misplaced");
    a_ex1_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_CAPTURE) |=> RDATA[LSB_BOT +: PW] == $past(prio[SRC_EX1]))
        else $error("Ext irq 1 read misplaced");
    a_t4_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_TIMER) |=> RDATA[LSB_HI +: PW] == $past(prio[SRC_T4]))
        else $error("Timer 4 read misplaced");
    a_oc4_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_TIMER) |=> RDATA[LSB_MID +: PW] == $past(prio[SRC_OC4]))
        else $error("Compare 4 read misplaced");
    a_oc3_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_TIMER) |=> RDATA[LSB_LOW +: PW] == $past(prio[SRC_OC3]))
        else $error("Compare 3 read misplaced");
    a_utx_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SERIAL) |=> RDATA[LSB_HI +: PW] == $past(prio[SRC_UTX]))
        else $error("Serial tx read misplaced");
    a_urx_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SERIAL) |=> RDATA[LSB_MID +: PW] == $past(prio[SRC_URX]))
        else $error("Serial rx read misplaced");
    a_ex2_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SERIAL) |=> RDATA[LSB_LOW +: PW] == $past(prio[SRC_EX2]))
        else $error("Ext irq 2 read misplaced");
    a_t5_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SERIAL) |=> RDATA[LSB_BOT +: PW] == $past(prio[SRC_T5]))
        else $error("Timer 5 read misplaced");
    a_spe_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SPI) |=> RDATA[LSB_LOW +: PW] == $past(prio[SRC_SPE]))
        else $error("SPI event read misplaced");
    a_spf_reads: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SPI) |=> RDATA[LSB_BOT +: PW] == $past(prio[SRC_SPF]))
        else $error("SPI fault read misplaced");

    // Gaps between fields that differ per register
    a_capture_gap_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_CAPTURE) |=> RDATA[LSB_LOW+PW:LSB_BOT+PW] == '0)
        else $error("Capture reg gap bits set");
    a_timer_gap_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_TIMER) |=> RDATA[LSB_BOT+PW:LSB_BOT] == '0)
        else $error("Timer reg low bits set");
    a_serial_gap_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && ADDR == ADDR_SERIAL) |=> !RDATA[LSB_LOW+PW])
        else $error("Serial reg gap bit set");

    // Marks fields written since reset; unmarked ones must keep the reset code
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            touched <= '0;
        end
        else
        begin
            touched <= touched | wr_f;
        end
    end

    genvar h;
    generate
        for (h = 0; h < NSRC; h++)
        begin : g_chk
            a_reset_hold: assert property (@(posedge CLK) disable iff (!RST_N)
                !touched[h] |-> prio[h] == PRIO_RESET)
                else $error("Unwritten field lost reset code");
            a_other_reg_kept: assert property (@(posedge CLK) disable iff (!RST_N)
                (WR && ADDR != adr[h]) |=> prio[h] == $past(prio[h]))
                else $error("Write reached field of another register");
            a_gate_off: assert property (@(posedge CLK) disable iff (!RST_N)
                !(FLAG[h] && ENABLE[h]) |-> !REQUEST[h])
                else $error("Request without flag and enable");
        end
    endgenerate
endmodule
